// File: design/bads_regs.svh
// Constants for the strap address decoder: thresholds, defaults, timing
`ifndef BADS_REGS_SVH
`define BADS_REGS_SVH

// ---------------------------------------------------------------------------
// Address arithmetic
// ---------------------------------------------------------------------------
`define BADS_BIN_WEIGHT      7'h0C
`define BADS_DEFAULT_ADDR    7'h7E
`define BADS_ADDR_RESET      7'h7E

// ---------------------------------------------------------------------------
// Bin thresholds in millivolts, converter full scale 3300 mV over 4096 codes
// ---------------------------------------------------------------------------
`define BADS_FULL_SCALE_MV   3300
`define BADS_MV2CODE(mv)     (((mv) * 4096) / `BADS_FULL_SCALE_MV)
`define BADS_SHORT_MAX_MV    97
`define BADS_BIN4_MIN_MV     276
`define BADS_BIN5_MIN_MV     359
`define BADS_BIN6_MIN_MV     468
`define BADS_BIN7_MIN_MV     609
`define BADS_BIN8_MIN_MV     793
`define BADS_BIN9_MIN_MV     1031
`define BADS_BIN10_MIN_MV    1342
`define BADS_BIN11_MIN_MV    1747
`define BADS_BIN11_MAX_MV    2225
`define BADS_OPEN_MIN_MV     2226

// ---------------------------------------------------------------------------
// Timing: bias settle time before each conversion
// ---------------------------------------------------------------------------
`define BADS_CLK_HZ          10000000
`define BADS_SETTLE_US       100
`define BADS_SETTLE_CYC      ((`BADS_SETTLE_US * (`BADS_CLK_HZ / 1000000)))

`endif

// File: design/bads_pkg.sv
// Types for the strap address decoder
package bads_pkg;

  typedef enum logic [5:0] {
    BADS_IDLE   = 6'b000001,
    BADS_SETTLE = 6'b000010,
    BADS_START  = 6'b000100,
    BADS_WAIT   = 6'b001000,
    BADS_RESOLV = 6'b010000,
    BADS_DONE   = 6'b100000
  } bads_state_t;

  typedef logic [3:0] bads_bin_t;

endpackage

// File: design/bads_bin_classify.sv
// Classifies one 12-bit strap conversion into an address bin
`timescale 1ns/1ps
`include "bads_regs.svh"

module bads_bin_classify #(
  parameter int ADC_W = 12
) (
  // Conversion code
  input  wire logic [ADC_W-1:0] i_code,
  // Result
  output bads_pkg::bads_bin_t   o_bin,
  output logic                  o_valid
);

  // Threshold codes are worked out for a 12-bit converter only
  if (ADC_W != 12) begin : g_bad_adc_w
    $error("bads_bin_classify: thresholds assume a 12-bit converter");
  end

  // ---------------------------------------------------------------------------
  // Threshold function
  // ---------------------------------------------------------------------------
  function automatic logic [ADC_W-1:0] mv_code(input int mv);
    mv_code = ADC_W'(`BADS_MV2CODE(mv));
  endfunction

  // Window minima grow by 1.3 per bin, tracking 1 % resistor tolerance
  always_comb begin
    o_bin   = 4'h0;
    o_valid = 1'b0;
    if (i_code >= mv_code(`BADS_OPEN_MIN_MV)) begin
      o_valid = 1'b0;
    end else if (i_code >= mv_code(`BADS_BIN11_MIN_MV)) begin
      o_bin   = 4'hB;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN10_MIN_MV)) begin
      o_bin   = 4'hA;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN9_MIN_MV)) begin
      o_bin   = 4'h9;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN8_MIN_MV)) begin
      o_bin   = 4'h8;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN7_MIN_MV)) begin
      o_bin   = 4'h7;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN6_MIN_MV)) begin
      o_bin   = 4'h6;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN5_MIN_MV)) begin
      o_bin   = 4'h5;
      o_valid = 1'b1;
    end else if (i_code >= mv_code(`BADS_BIN4_MIN_MV)) begin
      o_bin   = 4'h4;
      o_valid = 1'b1;
    end else begin
      // Short, or gap between short and bin 4: no valid bin
      o_valid = 1'b0;
    end
  end

endmodule

// File: design/bads_strap_decode.sv
// Power-up strap address decoder: bias, convert, classify, resolve address
`timescale 1ns/1ps
`include "bads_regs.svh"

module bads_strap_decode #(
  parameter int ADC_W      = 12,
  parameter int SETTLE_CYC = `BADS_SETTLE_CYC
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_resetn,
  // Converter interface
  input  wire logic             i_adc_done,
  input  wire logic [ADC_W-1:0] i_adc_code,
  output logic                  o_adc_start,
  output logic                  o_adc_sel_upper,
  // Bias current sources
  output logic                  o_bias_upper_en,
  output logic                  o_bias_lower_en,
  // Result
  output logic [6:0]            o_bus_addr,
  output logic                  o_addr_valid,
  output logic                  o_test_port_en
);

  // The settle down counter is 16 bits wide
  if (SETTLE_CYC < 1 || SETTLE_CYC > 65535) begin : g_bad_settle
    $error("bads_strap_decode: SETTLE_CYC out of range");
  end

  // ---------------------------------------------------------------------------
  // Input synchronisers (converter may sit in another domain)
  // ---------------------------------------------------------------------------
  logic             done_m_q, done_s_q;
  logic [ADC_W-1:0] code_m_q, code_s_q;

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      done_m_q <= 1'b0;
      done_s_q <= 1'b0;
      code_m_q <= '0;
      code_s_q <= '0;
    end else begin
      done_m_q <= i_adc_done;
      done_s_q <= done_m_q;
      code_m_q <= i_adc_code;
      code_s_q <= code_m_q;
    end
  end

  // ---------------------------------------------------------------------------
  // Classifier, shared between the two conversions
  // ---------------------------------------------------------------------------
  bads_pkg::bads_bin_t cls_bin;
  logic                cls_valid;

  bads_bin_classify #(
    .ADC_W (ADC_W)
  ) u_classify (
    .i_code  (code_s_q),
    .o_bin   (cls_bin),
    .o_valid (cls_valid)
  );

  // ---------------------------------------------------------------------------
  // Address arithmetic
  // ---------------------------------------------------------------------------
  // Sums above 127 do not fit seven bits; a wrapped sum could land on a
  // reserved address, so such straps fall back to the default instead
  function automatic logic [6:0] strap_addr(input bads_pkg::bads_bin_t up,
                                            input bads_pkg::bads_bin_t lo);
    logic [7:0] sum;
    sum = 8'(up) * 8'(`BADS_BIN_WEIGHT) + 8'(lo);
    if (sum[7]) begin
      strap_addr = `BADS_DEFAULT_ADDR;
    end else begin
      strap_addr = sum[6:0];
    end
  endfunction

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  bads_pkg::bads_state_t state_q, state_d;
  logic [15:0]           cnt_q, cnt_d;
  logic                  upper_q, upper_d;
  bads_pkg::bads_bin_t   bin_up_q, bin_up_d, bin_lo_q, bin_lo_d;
  logic                  ok_up_q, ok_up_d, ok_lo_q, ok_lo_d;
  logic                  start_q, start_d;
  logic                  bias_up_q, bias_up_d, bias_lo_q, bias_lo_d;
  logic [6:0]            addr_q, addr_d;
  logic                  valid_q, valid_d;
  logic                  test_q, test_d;
  logic                  done_seen_q, done_seen_d;
  logic                  done_old_q, done_old_d;

  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    upper_d     = upper_q;
    bin_up_d    = bin_up_q;
    bin_lo_d    = bin_lo_q;
    ok_up_d     = ok_up_q;
    ok_lo_d     = ok_lo_q;
    start_d     = 1'b0;
    bias_up_d   = bias_up_q;
    bias_lo_d   = bias_lo_q;
    addr_d      = addr_q;
    valid_d     = valid_q;
    test_d      = test_q;
    done_seen_d = done_s_q;
    done_old_d  = done_seen_q;
    case (state_q)
      bads_pkg::BADS_IDLE: begin
        // Upper strap first, bias on before converting
        upper_d   = 1'b1;
        bias_up_d = 1'b1;
        cnt_d     = 16'(SETTLE_CYC - 1);
        state_d   = bads_pkg::BADS_SETTLE;
      end
      bads_pkg::BADS_SETTLE: begin
        if (cnt_q == 16'h0000) begin
          start_d = 1'b1;
          state_d = bads_pkg::BADS_START;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      bads_pkg::BADS_START: begin
        state_d = bads_pkg::BADS_WAIT;
      end
      bads_pkg::BADS_WAIT: begin
        // Rising edge of the synchronised done flag marks the result; taken a
        // cycle late so the code word has passed both stages after done rose
        if (done_seen_q && !done_old_q) begin
          if (upper_q) begin
            bin_up_d  = cls_bin;
            ok_up_d   = cls_valid;
            bias_up_d = 1'b0;
            bias_lo_d = 1'b1;
            upper_d   = 1'b0;
            cnt_d     = 16'(SETTLE_CYC - 1);
            state_d   = bads_pkg::BADS_SETTLE;
          end else begin
            bin_lo_d  = cls_bin;
            ok_lo_d   = cls_valid;
            bias_lo_d = 1'b0;
            state_d   = bads_pkg::BADS_RESOLV;
          end
        end
      end
      bads_pkg::BADS_RESOLV: begin
        if (ok_up_q && ok_lo_q) begin
          addr_d = strap_addr(bin_up_q, bin_lo_q);
        end else begin
          addr_d = `BADS_DEFAULT_ADDR;
        end
        state_d = bads_pkg::BADS_DONE;
      end
      bads_pkg::BADS_DONE: begin
        // Held until the next reset; the address never changes at run time
        valid_d = 1'b1;
        test_d  = (addr_q == `BADS_DEFAULT_ADDR);
      end
      default: begin
        state_d = bads_pkg::BADS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_q     <= bads_pkg::BADS_IDLE;
      cnt_q       <= 16'h0000;
      upper_q     <= 1'b1;
      bin_up_q    <= 4'h0;
      bin_lo_q    <= 4'h0;
      ok_up_q     <= 1'b0;
      ok_lo_q     <= 1'b0;
      start_q     <= 1'b0;
      bias_up_q   <= 1'b0;
      bias_lo_q   <= 1'b0;
      addr_q      <= `BADS_ADDR_RESET;
      valid_q     <= 1'b0;
      test_q      <= 1'b0;
      done_seen_q <= 1'b0;
      done_old_q  <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      upper_q     <= upper_d;
      bin_up_q    <= bin_up_d;
      bin_lo_q    <= bin_lo_d;
      ok_up_q     <= ok_up_d;
      ok_lo_q     <= ok_lo_d;
      start_q     <= start_d;
      bias_up_q   <= bias_up_d;
      bias_lo_q   <= bias_lo_d;
      addr_q      <= addr_d;
      valid_q     <= valid_d;
      test_q      <= test_d;
      done_seen_q <= done_seen_d;
      done_old_q  <= done_old_d;
    end
  end

  assign o_adc_start     = start_q;
  assign o_adc_sel_upper = upper_q;
  assign o_bias_upper_en = bias_up_q;
  assign o_bias_lower_en = bias_lo_q;
  assign o_bus_addr      = addr_q;
  assign o_addr_valid    = valid_q;
  assign o_test_port_en  = test_q;

endmodule

// File: tb/bads_strap_monitor.sv
// Port assertions for the strap address decoder
`timescale 1ns/1ps
module bads_strap_monitor #(
  parameter int ADC_W = 12
) (
  // Clock and reset
  input wire logic             i_ref_clk,
  input wire logic             i_resetn,
  // Converter
  input wire logic             i_adc_done,
  input wire logic [ADC_W-1:0] i_adc_code,
  input wire logic             o_adc_start,
  input wire logic             o_adc_sel_upper,
  // Bias and result
  input wire logic             o_bias_upper_en,
  input wire logic             o_bias_lower_en,
  input wire logic [6:0]       o_bus_addr,
  input wire logic             o_addr_valid,
  input wire logic             o_test_port_en
);
  logic fault_q;
  logic fault_d;
  // -------------------------------------------------------------------------
  // Any code below bin 4 or above bin 11 seen this run
  // -------------------------------------------------------------------------
  always_comb begin
    fault_d = fault_q;
    if (i_adc_done && (i_adc_code < 12'h156 || i_adc_code > 12'hAC9)) begin
      fault_d = 1'b1;
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  property p_start_bias;
    o_adc_start |-> (o_adc_sel_upper ? o_bias_upper_en : o_bias_lower_en);
  endproperty
  a_start_bias: assert property (p_start_bias) else $error("start unbiased");
  property p_bias_one;
    !(o_bias_upper_en && o_bias_lower_en);
  endproperty
  a_bias_one: assert property (p_bias_one) else $error("both biases on");
  property p_order;
    $rose(o_bias_lower_en) |-> $fell(o_bias_upper_en) && !o_adc_sel_upper;
  endproperty
  a_order: assert property (p_order) else $error("lower before upper");
  property p_done_bias;
    o_addr_valid |-> !o_bias_upper_en && !o_bias_lower_en && !o_adc_start;
  endproperty
  a_done_bias: assert property (p_done_bias) else $error("bias after fix");
  property p_hold;
    o_addr_valid |=> o_addr_valid && $stable(o_bus_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("address moved");
  property p_range;
    $rose(o_addr_valid) && !fault_q |-> o_bus_addr >= 7'h34;
  endproperty
  a_range: assert property (p_range) else $error("address below formula");
  property p_fault;
    $rose(o_addr_valid) && fault_q |-> o_bus_addr == 7'h7E;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not default");
  property p_test;
    o_addr_valid |-> o_test_port_en == (o_bus_addr == 7'h7E);
  endproperty
  a_test: assert property (p_test) else $error("test port wrong");
endmodule

bind bads_strap_decode bads_strap_monitor #(.ADC_W(ADC_W)) u_bads_strap_monitor (
  .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_adc_done(i_adc_done),
  .i_adc_code(i_adc_code), .o_adc_start(o_adc_start), .o_adc_sel_upper(o_adc_sel_upper),
  .o_bias_upper_en(o_bias_upper_en), .o_bias_lower_en(o_bias_lower_en),
  .o_bus_addr(o_bus_addr), .o_addr_valid(o_addr_valid), .o_test_port_en(o_test_port_en)
);

// File: tb/bads_strap_model.sv
// Strap pins and converter on the far side of the decoder
`timescale 1ns/1ps
module bads_strap_model (
  // Decoder side
  input  wire logic        i_ref_clk,
  input  wire logic        i_start,
  input  wire logic        i_sel_upper,
  input  wire logic        i_bias_upper_en,
  input  wire logic        i_bias_lower_en,
  // Strap settings and answer delay
  input  wire logic [11:0] i_upper_code,
  input  wire logic [11:0] i_lower_code,
  input  wire logic [7:0]  i_delay,
  // Converter result
  output logic             o_done,
  output logic [11:0]      o_code
);
  logic [11:0] code;
  initial begin
    o_done = 1'b0;
    o_code = 12'hA5A;
    forever begin
      @(negedge i_ref_clk);
      if (i_start) begin
        // An unbiased pin sits at ground and reads as a short
        code = i_sel_upper ? (i_bias_upper_en ? i_upper_code : 12'h000)
                           : (i_bias_lower_en ? i_lower_code : 12'h000);
        repeat (i_delay) @(negedge i_ref_clk);
        o_code = code;
        o_done = 1'b1;
        repeat (6) @(negedge i_ref_clk);
        o_done = 1'b0;
        // Stale once done drops
        o_code = ~code;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
// Self-checking bench for the strap address decoder
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_top;
  logic        i_ref_clk;
  logic        i_resetn;
  logic        adc_done;
  logic [11:0] adc_code;
  logic        adc_start;
  logic        adc_sel_upper;
  logic        bias_upper_en;
  logic        bias_lower_en;
  logic [6:0]  bus_addr;
  logic        addr_valid;
  logic        test_port_en;
  logic [11:0] upper_code;
  logic [11:0] lower_code;
  logic [7:0]  delay;
  int          fail_count;
  int          checked;
  int          bin_min[8] = '{276, 359, 468, 609, 793, 1031, 1342, 1747};
  bads_strap_decode #(.SETTLE_CYC(4)) u_bads_strap_decode (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_adc_done(adc_done),
    .i_adc_code(adc_code), .o_adc_start(adc_start), .o_adc_sel_upper(adc_sel_upper),
    .o_bias_upper_en(bias_upper_en), .o_bias_lower_en(bias_lower_en),
    .o_bus_addr(bus_addr), .o_addr_valid(addr_valid), .o_test_port_en(test_port_en));
  bads_strap_model u_bads_strap_model (
    .i_ref_clk(i_ref_clk), .i_start(adc_start), .i_sel_upper(adc_sel_upper),
    .i_bias_upper_en(bias_upper_en), .i_bias_lower_en(bias_lower_en),
    .i_upper_code(upper_code), .i_lower_code(lower_code), .i_delay(delay),
    .o_done(adc_done), .o_code(adc_code));
  initial begin
    i_ref_clk = 1'b0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  // Full scale reads as the top code, not as a wrapped zero
  function automatic logic [11:0] mv2c(input int mv);
    int c;
    c = (mv * 4096) / 3300;
    return (c > 4095) ? 12'hFFF : 12'(c);
  endfunction
  task automatic finish_test();
    if (fail_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // -------------------------------------------------------------------------
  // One power-up with given strap voltages, judged once the address is fixed
  // -------------------------------------------------------------------------
  task automatic run(input int u_mv, input int l_mv, input int dly, input logic [6:0] exp);
    int n;
    @(negedge i_ref_clk);
    upper_code = mv2c(u_mv);
    lower_code = mv2c(l_mv);
    delay = 8'(dly);
    i_resetn = 1'b0;
    repeat (5) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    n = 0;
    while (addr_valid !== 1'b1 && n < 3000) begin
      @(negedge i_ref_clk);
      n++;
    end
    if (n == 3000) begin
      `CHK("addr_valid", 1'b1, addr_valid)
      finish_test();
    end else begin
      // Only this part sits on the bench bus: 0, 11, 12, 127, 126 stay free
      // of other devices
      `CHK("bus_addr", exp, bus_addr)
      `CHK("test_port_en", exp == 7'h7E, test_port_en)
    end
  endtask
  task automatic t_bins();
    for (int b = 4; b < 12; b++) begin
      run(359, bin_min[b-4], (b % 2) * 20, 7'(60 + b));
    end
  endtask
  task automatic t_top_bins();
    run(1031, 2225, 3, 7'h77);
    run(1342, 468, 0, 7'h7E);
  endtask
  task automatic t_short();
    run(97, 276, 5, 7'h7E);
    run(1747, 0, 0, 7'h7E);
  endtask
  task automatic t_open();
    run(276, 2226, 0, 7'h7E);
    run(3300, 276, 9, 7'h7E);
  endtask
  task automatic t_gap();
    run(200, 276, 0, 7'h7E);
    run(1747, 609, 0, 7'h7E);
  endtask
  initial begin
    i_resetn = 1'b0;
    upper_code = 12'h000;
    lower_code = 12'h000;
    delay = 8'h00;
    fail_count = 0;
    checked = 0;
    repeat (5) @(negedge i_ref_clk);
    i_resetn = 1'b1;
    t_bins();
    t_top_bins();
    t_short();
    t_open();
    t_gap();
    finish_test();
  end
endmodule
